// >>> verif/pssc_checker.sv
// Purpose: link checks between controller and memory ends
// Assumes: one clock, link signals seen on ref_clk
// Notes:   stalls and sleep mask the fixed two-edge data timing
`timescale 1ns/1ps
module pssc_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// link controls
	input wire logic clock_gate_n,
	input wire logic advance_not_load,
	input wire logic write_not_read,
	input wire logic chip_select_a_n,
	input wire logic chip_select_b_n,
	input wire logic chip_select_c,
	input wire logic sleep_request,
	// data enables
	input wire logic ctl_data_oe,
	input wire logic mem_data_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic sel;
	logic wr_ld;
	logic rd_ld;
	logic bdir_rd;
	logic bdir_wr;
	logic rd_any;
	logic wr_any;
	////////////////////////////////////////////////////////////////////////
	// three-way select
	assign sel = !chip_select_a_n && !chip_select_b_n && chip_select_c;
	assign wr_ld = sel && !advance_not_load && !clock_gate_n && !write_not_read;
	assign rd_ld = sel && !advance_not_load && !clock_gate_n && write_not_read;
	// advances inherit the direction of the last load
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bdir_rd <= 1'b0;
			bdir_wr <= 1'b0;
		end else if (!clock_gate_n && !advance_not_load) begin
			bdir_rd <= rd_ld;
			bdir_wr <= wr_ld;
		end
	end
	assign rd_any = rd_ld || (bdir_rd && advance_not_load && !clock_gate_n);
	assign wr_any = wr_ld || (bdir_wr && advance_not_load && !clock_gate_n);
	sequence run2_s;
		(!clock_gate_n && !sleep_request) [*2];
	endsequence
	sequence wr_s;
		wr_any && !sleep_request;
	endsequence
	sequence rd_s;
		rd_any && !sleep_request;
	endsequence
	////////////////////////////////////////////////////////////////////////
	write_data_a: assert property (wr_s ##1 run2_s |-> ctl_data_oe)
		else $error("write data not driven two edges after write");
	read_data_a: assert property (rd_s ##1 run2_s |-> mem_data_oe)
		else $error("read data not driven two edges after read");
	bus_excl_a: assert property (!(ctl_data_oe && mem_data_oe))
		else $error("both ends drive the data bus");
	write_origin_a: assert property (ctl_data_oe |->
		$past(wr_any, 2) || $past(clock_gate_n) || $past(clock_gate_n, 2))
		else $error("write data without a write two edges before");
	read_origin_a: assert property (mem_data_oe |->
		$past(rd_any, 2) || $past(clock_gate_n) || $past(clock_gate_n, 2))
		else $error("read data without a selected read before");
	stall_freeze_a: assert property (clock_gate_n && !sleep_request
		|=> $stable(mem_data_oe))
		else $error("output changed on an ignored edge");
	sleep_release_a: assert property (sleep_request [*3] |-> !mem_data_oe)
		else $error("memory drives data while asleep");
	wake_no_write_a: assert property ($fell(sleep_request) |->
		(advance_not_load || write_not_read) [*3])
		else $error("write issued during wake-up");
	sleep_idle_a: assert property ($rose(sleep_request) |->
		!ctl_data_oe && !mem_data_oe)
		else $error("sleep raised with data in flight");
endmodule

// >>> verif/test_pipelined_sram_cycle_and_sleep_control.sv
// Purpose: bench joining controller and memory across the link
// Assumes: memory contents unknown until written
// Notes:   read data is queued by a monitor and judged in order
`timescale 1ns/1ps
module test_pipelined_sram_cycle_and_sleep_control;
	localparam int AW = pssc_pkg::ADDR_W;
	localparam int DW = pssc_pkg::DATA_W;
	logic          ref_clk;
	logic          rstn;
	logic          cmd_valid;
	logic          cmd_ready;
	logic [2:0]    cmd;
	logic [AW-1:0] cmd_addr;
	logic          cmd_order;
	logic          cmd_stall;
	logic          wdata_valid;
	logic          wdata_ready;
	logic [DW-1:0] wdata;
	logic          rdata_valid;
	logic [DW-1:0] rdata;
	logic          asleep;
	logic [DW-1:0] bus_last;
	logic [DW-1:0] rq[$];
	int            failures;
	int            tests_run;
	int            cycles;
	////////////////////////////////////////////////////////////////////////
	pssc_link_if link ();
	// released bus flips so a stale value never reads as good
	assign link.data_bus = link.ctl_data_oe ? link.ctl_data_out :
		link.mem_data_oe ? link.mem_data_out : ~bus_last;
	always @(posedge ref_clk) bus_last <= link.data_bus;
	pssc_controller pssc_controller_i (.ref_clk(ref_clk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.cmd_addr(cmd_addr), .cmd_order(cmd_order), .cmd_stall(cmd_stall),
		.wdata_valid(wdata_valid), .wdata_ready(wdata_ready),
		.wdata(wdata), .rdata_valid(rdata_valid), .rdata(rdata),
		.link(link));
	pssc_memory pssc_memory_i (.ref_clk(ref_clk), .rstn(rstn),
		.link(link), .asleep(asleep));
	pssc_checker pssc_checker_i (.ref_clk(ref_clk), .rstn(rstn),
		.clock_gate_n(link.clock_gate_n),
		.advance_not_load(link.advance_not_load),
		.write_not_read(link.write_not_read),
		.chip_select_a_n(link.chip_select_a_n),
		.chip_select_b_n(link.chip_select_b_n),
		.chip_select_c(link.chip_select_c),
		.sleep_request(link.sleep_request),
		.ctl_data_oe(link.ctl_data_oe), .mem_data_oe(link.mem_data_oe));
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rdata_valid === 1'b1) rq.push_back(rdata);
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [DW-1:0] exp,
		input logic [DW-1:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// held until cmd_ready seen high before the taking edge
	task automatic issue(input logic [2:0] c, input logic [AW-1:0] a,
		input logic o, input bit last);
		int n;
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_addr <= a;
		cmd_order <= o;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 100);
		@(posedge ref_clk);
		if (n == 100) failures++;
		// an edge passes so a next call never re-raises valid at once
		if (last) begin
			cmd_valid <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task automatic push(input logic [DW-1:0] w);
		int n;
		wdata_valid <= 1'b1;
		wdata <= w;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (wdata_ready !== 1'b1 && n < 100);
		@(posedge ref_clk);
		if (n == 100) failures++;
	endtask
	task automatic take(input logic [DW-1:0] e);
		logic [DW-1:0] g;
		int t;
		g = 'x;
		for (t = 0; t < 50 && rq.size() == 0; t++) @(posedge ref_clk);
		if (rq.size() > 0) g = rq.pop_front();
		check("read data", e, g);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic test_fill_drain();
		int k;
		for (k = 0; k < 16; k++) push(DW'(32'hA000 + k));
		wdata_valid <= 1'b0;
		@(negedge ref_clk);
		check("full fifo ready", 16'h0000, {15'h0000, wdata_ready});
		@(posedge ref_clk);
		for (k = 0; k < 16; k++) issue(3'h2, AW'(32'h100 + k), 1'b0, k == 15);
		for (k = 0; k < 16; k++) issue(3'h1, AW'(32'h100 + k), 1'b0, k == 15);
		for (k = 0; k < 16; k++) take(DW'(32'hA000 + k));
		check("drained fifo ready", 16'h0001, {15'h0000, wdata_ready});
		$display("test fill_drain done");
	endtask
	task automatic test_forward();
		push(16'h1111);
		push(16'h2222);
		wdata_valid <= 1'b0;
		issue(3'h2, 10'h055, 1'b0, 0);
		issue(3'h2, 10'h055, 1'b0, 0);
		issue(3'h1, 10'h055, 1'b0, 1);
		take(16'h2222);
		$display("test forward done");
	endtask
	task automatic test_burst();
		int k;
		int j;
		for (k = 0; k < 4; k++) push(DW'(32'hB000 + k));
		wdata_valid <= 1'b0;
		for (k = 0; k < 4; k++) issue(3'h2, AW'(32'h020 + k), 1'b0, k == 3);
		for (k = 0; k < 2; k++) begin
			issue(3'h1, 10'h021, k[0], 0);
			for (j = 0; j < 3; j++) issue(3'h3, 10'h021, k[0], j == 2);
			for (j = 0; j < 4; j++)
				take(DW'(32'hB000 + ((k == 1) ? (1 ^ j) : ((1 + j) & 3))));
		end
		$display("test burst done");
	endtask
	task automatic test_stall();
		push(16'hC0DE);
		wdata_valid <= 1'b0;
		issue(3'h2, 10'h066, 1'b0, 1);
		cmd_stall <= 1'b1;
		repeat (3) @(posedge ref_clk);
		cmd_stall <= 1'b0;
		issue(3'h1, 10'h066, 1'b0, 1);
		cmd_stall <= 1'b1;
		repeat (2) @(posedge ref_clk);
		cmd_stall <= 1'b0;
		take(16'hC0DE);
		$display("test stall done");
	endtask
	task automatic test_sleep();
		// sleep must wait for the read in flight
		issue(3'h1, 10'h066, 1'b0, 0);
		issue(3'h4, 10'h000, 1'b0, 1);
		take(16'hC0DE);
		repeat (6) @(posedge ref_clk);
		check("asleep in sleep", 16'h0001, {15'h0000, asleep});
		issue(3'h5, 10'h000, 1'b0, 1);
		issue(3'h1, 10'h066, 1'b0, 1);
		take(16'hC0DE);
		repeat (8) @(posedge ref_clk);
		check("awake again", 16'h0000, {15'h0000, asleep});
		$display("test sleep done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd = 3'h0;
		cmd_addr = '0;
		cmd_order = 1'b0;
		cmd_stall = 1'b0;
		wdata_valid = 1'b0;
		wdata = '0;
		bus_last = 16'h5A5A;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		test_fill_drain();
		test_forward();
		test_burst();
		test_stall();
		test_sleep();
		give_verdict();
	end
endmodule

// >>> verilog/pssc_controller.sv
// Purpose: controller end, turns user commands into link cycles
// Assumes: one command per cycle when cmd_ready is high
// Notes:   write data queues in a fifo; a write waits for its word
`timescale 1ns/1ps
module pssc_controller #(
	parameter int AW = pssc_pkg::ADDR_W,
	parameter int DW = pssc_pkg::DATA_W
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// user commands
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic [2:0]    cmd,
	input  wire logic [AW-1:0] cmd_addr,
	input  wire logic          cmd_order,
	input  wire logic          cmd_stall,
	// write data
	input  wire logic          wdata_valid,
	output logic               wdata_ready,
	input  wire logic [DW-1:0] wdata,
	// read data
	output logic               rdata_valid,
	output logic [DW-1:0]      rdata,
	// link
	pssc_link_if.controller    link
);
	typedef enum logic [2:0] {
		PSSC_RUN   = 3'h1,
		PSSC_SLEEP = 3'h2,
		PSSC_WAKE  = 3'h4
	} pssc_state_type;

	pssc_state_type state, next_state;
	logic           fv, fr;
	logic [DW-1:0]  fd;
	logic [1:0]     wcnt, next_wcnt;
	logic [1:0]     rd_p, wr_p, next_rd_p, next_wr_p;
	logic           rd_q, next_rd_q, last_wr, next_last_wr;
	logic           is_rd, is_wr, is_cont, take, pend;

	pssc_fifo #(.WIDTH(DW), .DEPTH(pssc_pkg::FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (wdata_valid),
		.in_ready  (wdata_ready),
		.in_data   (wdata),
		.out_valid (fv),
		.out_ready (fr),
		.out_data  (fd)
	);

	assign is_rd   = cmd == pssc_pkg::CMD_READ;
	assign is_wr   = cmd == pssc_pkg::CMD_WRITE;
	assign is_cont = cmd == pssc_pkg::CMD_BURST;
	assign pend    = (rd_p | wr_p) != 2'h0 || rd_q || link.ctl_data_oe;

	////////////////////////////////////////////////////////////////////
	// sleep sequencing and acceptance
	always_comb begin
		next_state = state;
		next_wcnt  = wcnt;
		take       = 1'b0;
		cmd_ready  = 1'b0;
		unique case (state)
			PSSC_RUN: begin
				cmd_ready = !(cmd == pssc_pkg::CMD_SLEEP && pend)
					&& !((is_wr || (is_cont && last_wr)) && !fv)
					&& !cmd_stall;
				take = cmd_valid && cmd_ready;
				if (take && cmd == pssc_pkg::CMD_SLEEP)
					next_state = PSSC_SLEEP;
			end
			PSSC_SLEEP: begin
				cmd_ready = 1'b1;
				take = cmd_valid && cmd == pssc_pkg::CMD_WAKE;
				if (take) begin
					next_state = PSSC_WAKE;
					next_wcnt  = 2'(pssc_pkg::SLEEP_EXIT_CYCLES + 1);
				end
			end
			PSSC_WAKE: begin
				if (wcnt == 2'h0)
					next_state = PSSC_RUN;
				else
					next_wcnt = 2'(wcnt - 2'h1);
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// pipeline trackers for data phase
	logic run_take, adv_cyc, rd_ins, wr_ins;
	assign run_take = take && state == PSSC_RUN;
	// memory freezes on the edge that sees clock_gate_n high
	assign adv_cyc  = !link.clock_gate_n;
	// advance keeps direction of its load
	assign rd_ins   = run_take && (is_rd || (is_cont && !last_wr));
	assign wr_ins   = run_take && (is_wr || (is_cont && last_wr));
	assign fr = adv_cyc && wr_p[1];

	// a command on the link never meets a stalled edge
	always_comb begin
		next_rd_p    = {adv_cyc ? rd_p[0] : rd_p[1], rd_ins};
		next_wr_p    = {adv_cyc ? wr_p[0] : wr_p[1], wr_ins};
		next_rd_q    = adv_cyc ? rd_p[1] : rd_q;
		next_last_wr = last_wr;
		if (run_take && (is_rd || is_wr))
			next_last_wr = is_wr;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state                      <= PSSC_RUN;
			wcnt                       <= 2'h0;
			rd_p                       <= 2'h0;
			wr_p                       <= 2'h0;
			rd_q                       <= 1'b0;
			last_wr                    <= 1'b0;
			rdata_valid                <= 1'b0;
			rdata                      <= '0;
			link.clock_gate_n          <= 1'b0;
			link.advance_not_load      <= 1'b1;
			link.write_not_read        <= 1'b1;
			link.chip_select_a_n       <= 1'b1;
			link.chip_select_b_n       <= 1'b1;
			link.chip_select_c         <= 1'b0;
			link.output_drive_enable_n <= 1'b0;
			link.burst_order           <= pssc_pkg::BURST_LINEAR;
			link.sleep_request         <= 1'b0;
			link.address               <= '0;
			link.ctl_data_out          <= '0;
			link.ctl_data_oe           <= 1'b0;
		end else begin
			state       <= next_state;
			wcnt        <= next_wcnt;
			rd_p        <= next_rd_p;
			wr_p        <= next_wr_p;
			rd_q        <= next_rd_q;
			last_wr     <= next_last_wr;
			// read word taken while memory drives it
			rdata_valid <= adv_cyc && rd_q;
			rdata       <= link.data_bus;
			link.clock_gate_n     <= cmd_stall;
			// load, idle is a deselect load
			link.advance_not_load <= run_take && is_cont;
			link.write_not_read   <= !(run_take && is_wr);
			link.chip_select_a_n  <= !(run_take && (is_rd || is_wr));
			link.chip_select_b_n  <= !(run_take && (is_rd || is_wr));
			link.chip_select_c    <= run_take && (is_rd || is_wr);
			link.output_drive_enable_n <= 1'b0;
			link.burst_order      <= cmd_order;
			link.sleep_request    <= next_state == PSSC_SLEEP;
			if (run_take)
				link.address <= cmd_addr;
			if (adv_cyc) begin
				link.ctl_data_out <= fd;
				link.ctl_data_oe  <= wr_p[1];
			end
		end
	end
endmodule

// >>> verilog/pssc_fifo.sv
// Purpose: small valid/ready fifo for write data
// Assumes: same clock on both sides
// Notes:   no bypass, so a word takes one cycle to appear
`timescale 1ns/1ps
module pssc_fifo #(
	parameter int WIDTH = pssc_pkg::DATA_W,
	parameter int DEPTH = pssc_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PW:0]      count, next_count;
	logic             push, pop;

	always_comb begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = count;
		if (push && !pop)
			next_count = (PW+1)'(count + 1'b1);
		else if (pop && !push)
			next_count = (PW+1)'(count - 1'b1);
	end

	assign in_ready  = count != (PW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage holds no reset, it is qualified by count
	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// >>> verilog/pssc_link_if.sv
// Purpose: pin-level link between controller and sram
// Assumes: data bus split into out, in and output enable per end
// Notes:   the wire level is resolved by the bench from the enables
`timescale 1ns/1ps
interface pssc_link_if #(
	parameter int AW = pssc_pkg::ADDR_W,
	parameter int DW = pssc_pkg::DATA_W
);
	logic          clock_gate_n;
	logic          advance_not_load;
	logic          write_not_read;
	logic          chip_select_a_n;
	logic          chip_select_b_n;
	logic          chip_select_c;
	logic          output_drive_enable_n;
	logic          burst_order;
	logic          sleep_request;
	logic [AW-1:0] address;
	logic [DW-1:0] ctl_data_out;
	logic          ctl_data_oe;
	logic [DW-1:0] mem_data_out;
	logic          mem_data_oe;
	logic [DW-1:0] data_bus;

	modport controller (
		output clock_gate_n, advance_not_load, write_not_read,
		output chip_select_a_n, chip_select_b_n, chip_select_c,
		output output_drive_enable_n, burst_order, sleep_request,
		output address, ctl_data_out, ctl_data_oe,
		input  data_bus
	);
	modport memory (
		input  clock_gate_n, advance_not_load, write_not_read,
		input  chip_select_a_n, chip_select_b_n, chip_select_c,
		input  output_drive_enable_n, burst_order, sleep_request,
		input  address, data_bus,
		output mem_data_out, mem_data_oe
	);
endinterface

// >>> verilog/pssc_memory.sv
// Purpose: device end, pipelined sram with stall, burst and sleep
// Assumes: inputs come from controller flops on ref_clk
// Notes:   sleep_request is asynchronous and is synchronised first
`timescale 1ns/1ps
module pssc_memory #(
	parameter int AW = pssc_pkg::ADDR_W,
	parameter int DW = pssc_pkg::DATA_W
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// link
	pssc_link_if.memory link,
	// status
	output logic      asleep
);
	localparam int BW = pssc_pkg::BURST_W;
	logic [DW-1:0] mem [2**AW];

	////////////////////////////////////////////////////////////////////
	// sleep synchroniser and wake counter
	logic       zz_meta, zz_sync;
	logic       sleeping, next_sleeping;
	logic [1:0] wake_cnt, next_wake_cnt;
	logic       active;

	always_comb begin
		next_sleeping = sleeping;
		next_wake_cnt = wake_cnt;
		if (zz_sync) begin
			next_sleeping = 1'b1;
			next_wake_cnt = 2'(pssc_pkg::SLEEP_EXIT_CYCLES);
		end else if (wake_cnt != 2'h0) begin
			next_wake_cnt = 2'(wake_cnt - 2'h1);
		end else begin
			next_sleeping = 1'b0;
		end
	end
	// two sync flops give the bound
	assign active = !sleeping && !zz_sync;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			zz_meta  <= 1'b0;
			zz_sync  <= 1'b0;
			sleeping <= 1'b0;
			wake_cnt <= 2'h0;
		end else begin
			zz_meta  <= link.sleep_request;
			zz_sync  <= zz_meta;
			sleeping <= next_sleeping;
			wake_cnt <= next_wake_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// command decode and burst address
	logic          selected, edge_ok, do_load, do_adv;
	logic [AW-1:0] base, next_base, cur_addr;
	logic [BW-1:0] bcnt, next_bcnt, offs, step;
	logic          border, next_border, bwrite, next_bwrite;
	logic          bvalid, next_bvalid;

	assign selected = !link.chip_select_a_n && !link.chip_select_b_n
		&& link.chip_select_c;
	assign edge_ok = active && !link.clock_gate_n;
	assign do_load = edge_ok && !link.advance_not_load && selected;
	assign do_adv  = edge_ok && link.advance_not_load && bvalid;

	always_comb begin
		next_base   = base;
		next_bcnt   = bcnt;
		next_border = border;
		next_bwrite = bwrite;
		next_bvalid = bvalid;
		if (do_load) begin
			next_base   = link.address;
			next_bcnt   = '0;
			next_border = link.burst_order;
			next_bwrite = !link.write_not_read;
			next_bvalid = 1'b1;
		end else if (edge_ok && !link.advance_not_load) begin
			next_bvalid = 1'b0;
		end else if (do_adv) begin
			next_bcnt = BW'(bcnt + 1'b1);
		end
		if (!active)
			next_bvalid = 1'b0;
	end

	// linear adds, interleaved xors
	// load used element zero, so an advance issues the next one
	always_comb begin
		step = BW'(bcnt + 1'b1);
		if (border == pssc_pkg::BURST_INTERLEAVED)
			offs = base[BW-1:0] ^ step;
		else
			offs = BW'(base[BW-1:0] + step);
		cur_addr = {base[AW-1:BW], offs};
	end

	////////////////////////////////////////////////////////////////////
	// two-stage pipeline
	logic          op_v  [pssc_pkg::PIPE_DEPTH];
	logic          op_w  [pssc_pkg::PIPE_DEPTH];
	logic [AW-1:0] op_a  [pssc_pkg::PIPE_DEPTH];
	logic          issue, issue_w;
	logic [AW-1:0] issue_a;
	logic          do_write;
	logic [DW-1:0] rd_word, next_out;
	logic          next_oe;

	assign issue   = do_load || do_adv;
	assign issue_w = do_load ? !link.write_not_read : bwrite;
	assign issue_a = do_load ? link.address : cur_addr;
	assign do_write = edge_ok && op_v[1] && op_w[1];

	always_comb begin
		// forward write data landing this edge
		rd_word = mem[op_a[0]];
		if (do_write && op_a[1] == op_a[0])
			rd_word = link.data_bus;
		next_out = link.mem_data_out;
		next_oe  = link.mem_data_oe;
		if (!active) begin
			next_oe = 1'b0;
		end else if (edge_ok) begin
			next_out = rd_word;
			next_oe  = op_v[0] && !op_w[0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			base              <= '0;
			bcnt              <= '0;
			border            <= pssc_pkg::BURST_LINEAR;
			bwrite            <= 1'b0;
			bvalid            <= 1'b0;
			op_v[0]           <= 1'b0;
			op_v[1]           <= 1'b0;
			op_w[0]           <= 1'b0;
			op_w[1]           <= 1'b0;
			op_a[0]           <= '0;
			op_a[1]           <= '0;
			link.mem_data_out <= '0;
			link.mem_data_oe  <= 1'b0;
			asleep            <= 1'b0;
		end else begin
			base              <= next_base;
			bcnt              <= next_bcnt;
			border            <= next_border;
			bwrite            <= next_bwrite;
			bvalid            <= next_bvalid;
			link.mem_data_out <= next_out;
			link.mem_data_oe  <= next_oe;
			asleep            <= next_sleeping;
			if (!active) begin
				op_v[0] <= 1'b0;
				op_v[1] <= 1'b0;
			end else if (edge_ok) begin
				op_v[0] <= issue;
				op_w[0] <= issue_w;
				op_a[0] <= issue_a;
				op_v[1] <= op_v[0];
				op_w[1] <= op_w[0];
				op_a[1] <= op_a[0];
			end
		end
	end

	// array storage carries no reset
	always_ff @(posedge ref_clk) begin
		if (do_write)
			mem[op_a[1]] <= link.data_bus;
	end
endmodule

// >>> verilog/pssc_pkg.sv
// Purpose: shared constants for the pipelined sram cycle and sleep control
// Assumes: single 125 MHz clock, two-cycle late-write pipeline
// Notes:   widths are package defaults, modules may override
package pssc_pkg;
	localparam int ADDR_W        = 10;
	localparam int DATA_W        = 16;
	localparam int BURST_W       = 2;
	localparam int FIFO_DEPTH    = 16;
	localparam int CLK_PERIOD_PS = 8000;
	// sleep entry: inputs ignored within at most two clock periods
	localparam int SLEEP_ENTRY_INPUT_IGNORE_TIME_PS = 2 * CLK_PERIOD_PS;
	localparam int SLEEP_ENTRY_CYCLES =
		SLEEP_ENTRY_INPUT_IGNORE_TIME_PS / CLK_PERIOD_PS;
	// sleep exit: at least two clock periods before sampling again
	localparam int SLEEP_EXIT_INPUT_SAMPLE_TIME_PS = 2 * CLK_PERIOD_PS;
	localparam int SLEEP_EXIT_CYCLES =
		(SLEEP_EXIT_INPUT_SAMPLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PIPE_DEPTH    = 2;
	localparam logic BURST_LINEAR      = 1'h0;
	localparam logic BURST_INTERLEAVED = 1'h1;
	localparam logic [2:0] CMD_IDLE  = 3'h0;
	localparam logic [2:0] CMD_READ  = 3'h1;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	localparam logic [2:0] CMD_BURST = 3'h3;
	localparam logic [2:0] CMD_SLEEP = 3'h4;
	localparam logic [2:0] CMD_WAKE  = 3'h5;
endpackage
